// file: hdl/adctac_pkg.sv
// Purpose: shared constants and types for the tracking/accumulate control
// Assumes: 8-bit register port, converter clock at 250 MHz
// Notes:   offsets are byte addresses of the register port
package adctac_pkg;
   // register offsets
   localparam logic [7:0] OFS_ACC_CFG  = 8'hba;  // accumulator config
   localparam logic [7:0] OFS_CTRL     = 8'he8;  // converter control
   localparam logic [7:0] OFS_RES_LOW  = 8'hbd;  // result low byte
   localparam logic [7:0] OFS_RES_HIGH = 8'hbe;  // result high byte
   localparam logic [7:0] OFS_LT_LOW   = 8'hc5;  // threshold low byte
   localparam logic [7:0] OFS_LT_HIGH  = 8'hc6;  // threshold high byte
   // accumulator config fields
   localparam int ACC_WIDE_BIT = 7;              // wide resolution enable
   localparam int ACC_AE_BIT   = 6;              // accumulate enable
   localparam int ACC_SJ_LSB   = 3;              // shift/justify lsb
   localparam int ACC_RPT_LSB  = 0;              // repeat count lsb
   // converter control fields
   localparam int CTL_EN_BIT    = 7;             // converter enable
   localparam int CTL_SLEEP_BIT = 6;             // tracking shutdown
   localparam int CTL_BUSY_BIT  = 4;             // busy / software start
   localparam int CTL_LT_BIT    = 3;             // below-threshold flag
   localparam int CTL_TM_BIT    = 2;             // low-power tracking
   localparam int CTL_BURST_BIT = 1;             // burst enable
   localparam int CTL_PIN_BIT   = 0;             // start from pin
   // reset values
   localparam logic [7:0] ACC_CFG_RST = 8'h00;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] LT_RST      = 8'h00;
   // timing
   localparam int TRACK_SAR_CLKS = 3;            // low-power tracking time
   // shift/justify codes
   localparam logic [2:0] SJ_LEFT = 3'h4;        // left justified
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_TRACK = 2'b01,
      ST_CONV  = 2'b10,
      ST_DONE  = 2'b11
   } adctac_state_type;
   // request toward the analog core
   typedef struct packed {
      logic track;                               // sampling switch closed
      logic start;                               // one-cycle start pulse
   } adctac_core_req_type;
endpackage

// file: hdl/adctac_rpt.sv
// Purpose: decode the burst repeat-count code into a conversion count
// Assumes: code comes from a register on the same clock
// Notes:   count registered; reserved codes give one conversion
`timescale 1ns/1ps
module adctac_rpt (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // code in, count out
   input  wire logic [2:0] code,
   output logic      [6:0] count
);
   // registered decode of the repeat code
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count <= 7'h01;
      end else begin
         unique case (code)
            3'h1:    count <= 7'h04;
            3'h2:    count <= 7'h08;
            3'h3:    count <= 7'h10;
            3'h4:    count <= 7'h20;
            3'h5:    count <= 7'h40;
            default: count <= 7'h01;   // 000 and reserved codes
         endcase
      end
   end
endmodule

// file: hdl/adctac_top.sv
// Purpose: tracking, accumulation and formatting control of the converter
// Assumes: core answers each start with done and a 12-bit code
// Notes:   external start pin is synchronised before use
`timescale 1ns/1ps
module adctac_top (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // external start pin
   input  wire logic        ext_convert_start_pin,
   // analog core
   input  wire logic        core_done,
   input  wire logic [11:0] core_code,
   output adctac_pkg::adctac_core_req_type core_req,
   output logic             wide_resolution_enable,
   output logic             lessthan_flag
);
   // software-visible registers
   logic [7:0]  acc_cfg_reg;         // accumulator configuration
   logic [7:0]  ctrl_reg;            // converter control (busy excluded)
   logic [15:0] lessthan_threshold;  // window compare value
   logic [15:0] acc_reg;             // raw accumulator
   logic        busy_reg;            // conversion sequence active
   logic        lt_reg;              // below-threshold flag
   // sequencer
   adctac_pkg::adctac_state_type state_reg;
   logic [1:0]  track_cnt_reg;       // low-power tracking counter
   logic [6:0]  conv_left_reg;       // conversions left in burst
   logic [6:0]  rpt_count;           // decoded repeat count
   logic        first_reg;           // first conversion of a burst
   // pin synchroniser and edge
   logic        pin_meta_reg;
   logic        pin_sync_reg;
   logic        pin_prev_reg;
   logic        pin_rise;
   // decoded controls
   logic        enable;
   logic        sleep;
   logic        lp_mode;
   logic        burst;
   logic        pin_mode;
   logic        wr_busy;
   logic        accum;
   logic [15:0] fmt_result;

   assign enable   = ctrl_reg[adctac_pkg::CTL_EN_BIT];
   assign sleep    = ctrl_reg[adctac_pkg::CTL_SLEEP_BIT];
   assign lp_mode  = ctrl_reg[adctac_pkg::CTL_TM_BIT];
   assign burst    = ctrl_reg[adctac_pkg::CTL_BURST_BIT];
   assign pin_mode = ctrl_reg[adctac_pkg::CTL_PIN_BIT];
   assign accum    = acc_cfg_reg[adctac_pkg::ACC_AE_BIT];
   assign wr_busy  = reg_wr && (reg_addr == adctac_pkg::OFS_CTRL) &&
                     reg_wdata[adctac_pkg::CTL_BUSY_BIT];
   assign pin_rise = pin_sync_reg && !pin_prev_reg;

   // format accumulator per shift/justify code
   function automatic logic [15:0] fmt(input logic [15:0] v,
                                       input logic [2:0]  sj,
                                       input logic        wide);
      logic [15:0] r;
      r = 16'h0000;
      unique case (sj)
         3'h0: r = v;
         3'h1: r = v >> 1;
         3'h2: r = v >> 2;
         3'h3: r = v >> 3;
         adctac_pkg::SJ_LEFT:
            r = wide ? {v[11:0], 4'h0} : {v[9:0], 6'h00};
         default: r = v;                              // reserved
      endcase
      return r;
   endfunction

   assign fmt_result = fmt(acc_reg, acc_cfg_reg[adctac_pkg::ACC_SJ_LSB +: 3],
                           acc_cfg_reg[adctac_pkg::ACC_WIDE_BIT]);

   // repeat decode
   adctac_rpt u_rpt (
      .core_clk (core_clk),
      .rstn     (rstn),
      .code     (acc_cfg_reg[adctac_pkg::ACC_RPT_LSB +: 3]),
      .count    (rpt_count)
   );

   // two-flop synchroniser and edge history on start pin
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg <= ext_convert_start_pin;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // accumulator config register, all bits stored
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc_cfg_reg <= adctac_pkg::ACC_CFG_RST;
      end else if (reg_wr && reg_addr == adctac_pkg::OFS_ACC_CFG) begin
         acc_cfg_reg <= reg_wdata;
      end
   end

   // control register, busy bit handled by sequencer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= adctac_pkg::CTRL_RST;
      end else if (reg_wr && reg_addr == adctac_pkg::OFS_CTRL) begin
         ctrl_reg <= reg_wdata & 8'he7;
      end
   end

   // threshold bytes
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lessthan_threshold <= {adctac_pkg::LT_RST, adctac_pkg::LT_RST};
      end else if (reg_wr) begin
         if (reg_addr == adctac_pkg::OFS_LT_HIGH) begin
            lessthan_threshold[15:8] <= reg_wdata;
         end
         if (reg_addr == adctac_pkg::OFS_LT_LOW) begin
            lessthan_threshold[7:0] <= reg_wdata;
         end
      end
   end

   // sequencer: track, convert, accumulate
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg     <= adctac_pkg::ST_IDLE;
         track_cnt_reg <= 2'h0;
         conv_left_reg <= 7'h00;
         first_reg     <= 1'b0;
         busy_reg      <= 1'b0;
      end else begin
         unique case (state_reg)
            adctac_pkg::ST_IDLE: begin
               track_cnt_reg <= 2'h0;
               // start from software or pin rising edge
               if (enable && (wr_busy || (pin_mode && pin_rise))) begin
                  busy_reg      <= 1'b1;
                  first_reg     <= 1'b1;
                  conv_left_reg <= burst ? rpt_count : 7'h01;
                  if (lp_mode && !(pin_mode && pin_rise)) begin
                     state_reg <= adctac_pkg::ST_TRACK;
                  end else begin
                     state_reg <= adctac_pkg::ST_CONV;
                  end
               end
            end
            adctac_pkg::ST_TRACK: begin
               // three converter clocks of tracking
               if (track_cnt_reg ==
                   2'(adctac_pkg::TRACK_SAR_CLKS - 1)) begin
                  track_cnt_reg <= 2'h0;
                  state_reg     <= adctac_pkg::ST_CONV;
               end else begin
                  track_cnt_reg <= track_cnt_reg + 2'h1;
               end
            end
            adctac_pkg::ST_CONV: begin
               if (core_done) begin
                  first_reg     <= 1'b0;
                  conv_left_reg <= conv_left_reg - 7'h01;
                  if (conv_left_reg == 7'h01) begin
                     state_reg <= adctac_pkg::ST_DONE;
                  end else if (lp_mode) begin
                     state_reg <= adctac_pkg::ST_TRACK;
                  end
               end
            end
            adctac_pkg::ST_DONE: begin
               busy_reg  <= 1'b0;
               state_reg <= adctac_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // analog core requests, tracking switch and start pulse
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         core_req <= '0;
      end else begin
         core_req.start <= (state_reg != adctac_pkg::ST_CONV) &&
                           (state_reg != adctac_pkg::ST_DONE) &&
                           (((state_reg == adctac_pkg::ST_IDLE) && enable &&
                             (wr_busy || (pin_mode && pin_rise)) &&
                             !(lp_mode && !(pin_mode && pin_rise))) ||
                            ((state_reg == adctac_pkg::ST_TRACK) &&
                             (track_cnt_reg ==
                              2'(adctac_pkg::TRACK_SAR_CLKS - 1)))) ||
                           ((state_reg == adctac_pkg::ST_CONV) && core_done &&
                            conv_left_reg != 7'h01 && !lp_mode);
         if (!enable || sleep) begin
            core_req.track <= 1'b0;
         end else if (state_reg == adctac_pkg::ST_CONV) begin
            core_req.track <= 1'b0;
         end else if (lp_mode && pin_mode) begin
            core_req.track <= !pin_sync_reg;
         end else if (lp_mode) begin
            core_req.track <= (state_reg == adctac_pkg::ST_TRACK);
         end else begin
            core_req.track <= 1'b1;
         end
      end
   end

   // result accumulator: load, add, or clear on zero write
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc_reg <= 16'h0000;
      end else if (state_reg == adctac_pkg::ST_CONV && core_done) begin
         if (burst) begin
            acc_reg <= (first_reg ? 16'h0000 : acc_reg) +
                       {4'h0, core_code};
         end else if (accum) begin
            acc_reg <= acc_reg + {4'h0, core_code};
         end else begin
            acc_reg <= {4'h0, core_code};
         end
      end else if (reg_wr && reg_wdata == 8'h00 &&
                   (reg_addr == adctac_pkg::OFS_RES_LOW ||
                    reg_addr == adctac_pkg::OFS_RES_HIGH)) begin
         acc_reg <= 16'h0000;
      end
   end

   // below-threshold compare at end of conversion or burst
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lt_reg <= 1'b0;
      end else if (state_reg == adctac_pkg::ST_DONE) begin
         lt_reg <= (fmt_result < lessthan_threshold);
      end else if (state_reg == adctac_pkg::ST_IDLE && wr_busy) begin
         lt_reg <= 1'b0;
      end
   end

   // flag and mode outputs
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lessthan_flag          <= 1'b0;
         wide_resolution_enable <= 1'b0;
      end else begin
         lessthan_flag          <= lt_reg;
         wide_resolution_enable <=
            acc_cfg_reg[adctac_pkg::ACC_WIDE_BIT];
      end
   end

   // read data, one cycle after read strobe
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            adctac_pkg::OFS_ACC_CFG:
               reg_rdata <= acc_cfg_reg & 8'hbf;
            adctac_pkg::OFS_CTRL:
               reg_rdata <= ctrl_reg | {3'h0, busy_reg, lt_reg, 3'h0};
            adctac_pkg::OFS_RES_LOW:  reg_rdata <= fmt_result[7:0];
            adctac_pkg::OFS_RES_HIGH: reg_rdata <= fmt_result[15:8];
            adctac_pkg::OFS_LT_LOW:   reg_rdata <= lessthan_threshold[7:0];
            adctac_pkg::OFS_LT_HIGH:  reg_rdata <= lessthan_threshold[15:8];
            default:                  reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// file: verification/adctac_asserts.sv
// Purpose: port checks of the tracking/accumulate control
// Assumes: mode bits are shadowed from writes to the control register
// Notes:   bound onto every adctac_top instance
`timescale 1ns/1ps
module adctac_asserts (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // pin and core
   input wire logic       ext_convert_start_pin,
   input wire logic       core_done,
   input adctac_pkg::adctac_core_req_type core_req,
   input wire logic       wide_resolution_enable
);
   logic [7:0] ctl_q;  // shadow of control writes
   logic       conv_q; // conversion in flight
   wire        lp_m = ctl_q[2] && !ctl_q[0];            // timed low power
   wire        pin_m = ctl_q[2] && ctl_q[0];            // pin low power
   wire        nrm_m = ctl_q[7] && (ctl_q & 8'h46) == 8'h00; // continuous
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // shadow the mode bits as the block takes them
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) ctl_q <= 8'h00;
      else if (reg_wr && reg_addr == adctac_pkg::OFS_CTRL) ctl_q <= reg_wdata;
   end
   // start opens a conversion, done closes it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) conv_q <= 1'b0;
      else if (core_req.start) conv_q <= 1'b1;
      else if (core_done) conv_q <= 1'b0;
   end
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   ae_zero_a: assert property ($past(reg_rd) &&
      $past(reg_addr) == adctac_pkg::OFS_ACC_CFG |-> !reg_rdata[6])
      else $error("accumulate enable read back as one");
   unmapped_zero_a: assert property ($past(reg_rd) && !($past(reg_addr)
      inside {8'hba, 8'he8, 8'hbd, 8'hbe, 8'hc5, 8'hc6}) |-> reg_rdata == 0)
      else $error("unmapped read not zero");
   wide_copy_a: assert property (reg_wr &&
      reg_addr == adctac_pkg::OFS_ACC_CFG && reg_wdata[7]
      |-> ##[1:2] wide_resolution_enable)
      else $error("wide resolution output not set");
   start_pulse_a: assert property (core_req.start |=> (!core_req.start)[*2])
      else $error("start not a lone pulse");
   lp_track_a: assert property (core_req.start && lp_m |->
      core_req.track && $past(core_req.track) &&
      $past(core_req.track, 2))
      else $error("start without three tracking cycles");
   normal_track_a: assert property (core_done && nrm_m
      |-> ##[1:2] core_req.track)
      else $error("tracking not resumed after conversion");
   sleep_track_a: assert property (ctl_q[6] && $past(ctl_q[6], 3) &&
      !conv_q |-> !core_req.track)
      else $error("tracking while shut down");
   pin_track_a: assert property ((ext_convert_start_pin[*5] ##0
      (pin_m && !conv_q)) |-> !core_req.track)
      else $error("tracking while start pin high");
   // main scenarios reached
   lp_start_c: cover property (core_req.start && lp_m);
   pin_start_c: cover property (core_req.start && pin_m);
   burst_done_c: cover property (core_done && ctl_q[1]);
endmodule
bind adctac_top adctac_asserts i_chk (.core_clk, .rstn, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_convert_start_pin,
   .core_done, .core_req, .wide_resolution_enable);

// file: verification/adctac_core_model.sv
// Purpose: behavioural converter core answering start pulses
// Assumes: one start at a time, as the control block issues them
// Notes:   code shows inverted data except beside done
`timescale 1ns/1ps
module adctac_core_model (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // request and stimulus
   input  adctac_pkg::adctac_core_req_type core_req,
   input  wire logic [11:0] code_in,
   input  wire logic        slow,
   // answer
   output logic             core_done,
   output logic      [11:0] core_code
);
   logic [3:0] cnt_q; // cycles left of the conversion
   // prompt or slow conversion, done one cycle long
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q     <= 4'h0;
         core_done <= 1'b0;
      end else begin
         core_done <= cnt_q == 4'h1;
         if (core_req.start) cnt_q <= slow ? 4'h9 : 4'h2;
         else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      end
   end
   // stale code never looks valid
   assign core_code = core_done ? code_in : ~code_in;
endmodule

// file: verification/adctac_top_test.sv
// Purpose: self-checking bench of the tracking/accumulate control
// Assumes: core model answers each start within ten cycles
// Notes:   accumulator config writes keep the repeat field zero outside burst
`timescale 1ns/1ps
module adctac_top_test;
   logic        core_clk, rstn, reg_wr, reg_rd, ext_convert_start_pin;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        core_done, wide_resolution_enable, lessthan_flag, slow;
   logic [11:0] core_code, mcode;
   adctac_pkg::adctac_core_req_type core_req;
   int          num_errors, n_tests, dones;
   adctac_top i_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .ext_convert_start_pin, .core_done, .core_code,
      .core_req, .wide_resolution_enable, .lessthan_flag);
   adctac_core_model i_core (.core_clk, .rstn, .core_req, .code_in(mcode),
      .slow, .core_done, .core_code);
   // 250 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // count finished conversions
   always @(posedge core_clk) if (core_done) dones <= dones + 1;
   task automatic print_verdict();
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask
   // read data taken in the cycle after the strobe
   task automatic rchk(logic [7:0] a, logic [7:0] exp, string name);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 chk(name, {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   task automatic res(logic [15:0] exp);
      rchk(adctac_pkg::OFS_RES_HIGH, exp[15:8], "result_high");
      rchk(adctac_pkg::OFS_RES_LOW, exp[7:0], "result_low");
   endtask
   // software start, wait for n conversions, then no extra ones
   task automatic conv(logic [7:0] mode, int n);
      int base, i;
      wr(adctac_pkg::OFS_CTRL, 8'h80 | mode);
      base = dones;
      wr(adctac_pkg::OFS_CTRL, 8'h90 | mode);
      for (i = 0; i < 3000 && dones < base + n; i++) @(posedge core_clk);
      if (i == 3000) begin
         num_errors++;
         print_verdict();
      end
      repeat (20) @(posedge core_clk);
      #1 chk("conversions", 16'(base + n), 16'(dones));
   endtask
   task automatic t_regs();
      rchk(adctac_pkg::OFS_ACC_CFG, 8'h00, "acc_cfg");
      rchk(adctac_pkg::OFS_LT_HIGH, 8'h00, "lt_high");
      rchk(adctac_pkg::OFS_LT_LOW, 8'h00, "lt_low");
      wr(adctac_pkg::OFS_LT_HIGH, 8'ha5);
      wr(adctac_pkg::OFS_LT_LOW, 8'h5a);
      rchk(adctac_pkg::OFS_LT_HIGH, 8'ha5, "lt_high");
      rchk(adctac_pkg::OFS_LT_LOW, 8'h5a, "lt_low");
      rchk(8'h00, 8'h00, "unmapped");
      wr(adctac_pkg::OFS_ACC_CFG, 8'hc0);
      rchk(adctac_pkg::OFS_ACC_CFG, 8'h80, "acc_cfg");
      chk("wide", 16'h1, {15'h0, wide_resolution_enable});
      wr(adctac_pkg::OFS_ACC_CFG, 8'h00);
      repeat (2) @(posedge core_clk);
      #1 chk("wide", 16'h0, {15'h0, wide_resolution_enable});
   endtask
   // load, accumulate, clear by zero write
   task automatic t_acc();
      mcode <= 12'h155;
      conv(8'h00, 1);
      conv(8'h00, 1);
      res(16'h0155);
      wr(adctac_pkg::OFS_ACC_CFG, 8'h40);
      wr(adctac_pkg::OFS_RES_LOW, 8'h00);
      res(16'h0000);
      mcode <= 12'h0aa;
      slow  <= 1'b1;
      conv(8'h00, 1);
      conv(8'h00, 1);
      res(16'h0154);
      slow  <= 1'b0;
      wr(adctac_pkg::OFS_RES_HIGH, 8'h00);
      conv(8'h00, 1);
      res(16'h00aa);
      wr(adctac_pkg::OFS_ACC_CFG, 8'h00);
   endtask
   // every format code, threshold both ways
   task automatic t_fmt();
      logic [15:0] exp [6] = '{16'h02b7, 16'h015b, 16'h00ad, 16'h0056,
                               16'hadc0, 16'h2b70};
      logic [7:0]  cfg [6] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'ha0};
      int i;
      wr(adctac_pkg::OFS_LT_HIGH, 8'h03);
      wr(adctac_pkg::OFS_LT_LOW, 8'h00);
      mcode <= 12'h2b7;
      conv(8'h00, 1);
      chk("lt_flag", 16'h1, {15'h0, lessthan_flag});
      rchk(adctac_pkg::OFS_CTRL, 8'h88, "ctrl");
      for (i = 0; i < 6; i++) begin
         wr(adctac_pkg::OFS_ACC_CFG, cfg[i]);
         res(exp[i]);
      end
      wr(adctac_pkg::OFS_ACC_CFG, 8'h00);
      wr(adctac_pkg::OFS_LT_HIGH, 8'h02);
      conv(8'h00, 1);
      chk("lt_flag", 16'h0, {15'h0, lessthan_flag});
      rchk(adctac_pkg::OFS_CTRL, 8'h80, "ctrl");
   endtask
   // each repeat code, code one gives the count as result
   task automatic t_burst();
      int cnt [6] = '{1, 4, 8, 16, 32, 64};
      int i;
      mcode <= 12'h001;
      for (i = 0; i < 6; i++) begin
         wr(adctac_pkg::OFS_ACC_CFG, 8'(i));
         conv(8'h02, cnt[i]);
         res(16'(cnt[i]));
      end
      wr(adctac_pkg::OFS_ACC_CFG, 8'h01);
      conv(8'h06, 4);
      wr(adctac_pkg::OFS_ACC_CFG, 8'h00);
   endtask
   // pin low tracks, rising edge converts; trk is tracking with pin high
   task automatic t_pin(logic [7:0] mode, logic [15:0] trk);
      int base, i;
      wr(adctac_pkg::OFS_CTRL, mode);
      base = dones;
      repeat (8) @(posedge core_clk);
      #1 chk("track", 16'h1, {15'h0, core_req.track});
      @(posedge core_clk);
      ext_convert_start_pin <= 1'b1;
      for (i = 0; i < 100 && dones == base; i++) @(posedge core_clk);
      if (i == 100) begin
         num_errors++;
         print_verdict();
      end
      repeat (8) @(posedge core_clk);
      #1 chk("track", trk, {15'h0, core_req.track});
      chk("conversions", 16'(base + 1), 16'(dones));
      @(posedge core_clk);
      ext_convert_start_pin <= 1'b0;
   endtask
   // shutdown stops tracking, continuous mode brings it back
   task automatic t_sleep();
      wr(adctac_pkg::OFS_CTRL, 8'hc0);
      repeat (6) @(posedge core_clk);
      #1 chk("track", 16'h0, {15'h0, core_req.track});
      wr(adctac_pkg::OFS_CTRL, 8'h80);
      repeat (6) @(posedge core_clk);
      #1 chk("track", 16'h1, {15'h0, core_req.track});
   endtask
   initial begin
      num_errors = 0;
      n_tests = 0;
      rstn = 1'b0;
      {reg_wr, reg_rd, ext_convert_start_pin, slow} = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      mcode = 12'h000;
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      t_regs();
      t_acc();
      t_fmt();
      t_burst();
      conv(8'h04, 1);
      t_pin(8'h85, 16'h0);
      t_pin(8'h81, 16'h1);
      t_sleep();
      print_verdict();
   end
endmodule
